/* File: oob_burst_port.sv */
// oob burst sender and burst-train detector used by each end
// assumes rx_burst is synchronous to sys_clk
module oob_burst_port
   import oob_link_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic send,
   input  wire logic send_wake,
   input  wire logic hold,
   output logic      busy,
   output logic      tx_burst,
   input  wire logic rx_burst,
   output logic      rx_reset_end,
   output logic      rx_wake_end
);
   // ----------------------------------------------------------------
   // sender
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {tx_off = 2'b00, tx_on = 2'b01, tx_gap = 2'b11, tx_tail = 2'b10} tx_t;
   tx_t        tx_state, next_tx_state;
   logic [2:0] left, next_left;
   ocnt_t      tcnt, next_tcnt;
   logic       wake, next_wake;
   logic       next_tx_burst;

   // same six-burst train for reset and init, only the gap length tells wake apart
   always_comb begin
      next_tx_state = tx_state;
      next_left     = left;
      next_tcnt     = tcnt + CNT_ONE;
      next_wake     = wake;
      case (tx_state)
         tx_on: if (tcnt == BURST_CYC - CNT_ONE) begin
            next_tcnt = '0;
            if (left != '0) begin
               next_left     = left - RUN_ONE;
               next_tx_state = tx_gap;
            end else if (hold && !wake) begin
               next_tx_state = tx_gap;
            end else begin
               next_tx_state = tx_tail;
            end
         end
         tx_gap: if (tcnt == (wake ? WAKE_GAP_CYC : GAP_CYC) - CNT_ONE) begin
            next_tcnt     = '0;
            next_tx_state = tx_on;
         end
         tx_tail: if (tcnt == HOLD_CYC - CNT_ONE) begin
            next_tx_state = tx_off;
         end
         default: next_tcnt = '0;
      endcase
      if (send) begin                           // a new request restarts the train
         next_tx_state = tx_on;
         next_left     = SEQ_BURSTS - RUN_ONE;
         next_tcnt     = '0;
         next_wake     = send_wake;
      end
      next_tx_burst = (next_tx_state == tx_on);
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tx_state <= tx_off;
         left     <= '0;
         tcnt     <= '0;
         wake     <= 1'b0;
         tx_burst <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         left     <= next_left;
         tcnt     <= next_tcnt;
         wake     <= next_wake;
         tx_burst <= next_tx_burst;
      end
   end

   assign busy = (tx_state != tx_off);

   // ----------------------------------------------------------------
   // detector
   // ----------------------------------------------------------------
   logic       prev, rkind, next_rkind;
   logic [2:0] rcnt, next_rcnt;
   ocnt_t      gcnt, next_gcnt;
   logic       next_reset_end, next_wake_end;
   logic       gap_rst, gap_wake;

   // a gap outside both windows breaks the train and it starts over
   always_comb begin
      gap_rst        = (gcnt >= GAP_MIN_CYC) && (gcnt <= GAP_MAX_CYC);
      gap_wake       = (gcnt >= WGAP_MIN_CYC) && (gcnt < GAP_MIN_CYC);
      next_rcnt      = rcnt;
      next_rkind     = rkind;
      next_gcnt      = (gcnt == CNT_SAT) ? gcnt : gcnt + CNT_ONE;
      next_reset_end = 1'b0;
      next_wake_end  = 1'b0;
      if (rx_burst) begin
         next_gcnt = '0;
      end
      if (rx_burst && !prev) begin
         if (rcnt == '0) begin
            next_rcnt = RUN_ONE;
         end else if ((gap_rst || gap_wake) && (rcnt == RUN_ONE || rkind == gap_wake)) begin
            next_rkind = gap_wake;
            next_rcnt  = (rcnt == DET_BURSTS) ? rcnt : rcnt + RUN_ONE;
         end else begin
            next_rcnt = RUN_ONE;
         end
      end
      if (!rx_burst && gcnt == GAP_MAX_CYC) begin
         next_rcnt = '0;                        // silence past the longest gap ends the train
         if (rcnt == DET_BURSTS) begin
            next_reset_end = !rkind;
            next_wake_end  = rkind;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         prev         <= 1'b0;
         rkind        <= 1'b0;
         rcnt         <= '0;
         gcnt         <= CNT_SAT;
         rx_reset_end <= 1'b0;
         rx_wake_end  <= 1'b0;
      end else begin
         prev         <= rx_burst;
         rkind        <= next_rkind;
         rcnt         <= next_rcnt;
         gcnt         <= next_gcnt;
         rx_reset_end <= next_reset_end;
         rx_wake_end  <= next_wake_end;
      end
   end
endmodule // oob_burst_port

/* File: oob_device_end.sv */
// device end of the oob handshake: init request, wake answer, speed stepping, lock
// assumes the host end sits on the far side of oob_link_if
// assumes fastest_rate >= slowest_rate and both stay steady during a handshake

// How it works
// - only this end sends init requests
// - init train equals host reset train
// - host answers init with its wake
// - after host wake, send six-burst wake
// - then aligns nonstop from fastest rate
// - no host align in window: step down
// - slowest rate timed out: error state
// - host sends d10.2 at slowest rate
// - host locks, echoes aligns at same rate
// - host locks within one align window
// - host waits long for first align
// - host retries power-on until told stop
// - lock on host aligns, then send sync
// - three non-align primitives mean link up
// - host resets at power-up, then goes quiet
// - host reset end triggers init request
// - init request possible at any time
// - burst is 160 oob unit intervals
// - reset gaps are 320 ns nominal
// - detect four bursts, gaps 175-525 ns
// - idle 525 ns after the last burst
module oob_device_end
   import oob_link_pkg::*;
#(
   parameter tmr_t ALIGN_TIMEOUT = ALIGN_WAIT_CYC
)
(
   input  wire logic  sys_clk,
   input  wire logic  resetn,
   oob_link_if.dev    link,
   input  wire logic  start_init,
   input  wire rate_t fastest_rate,
   input  wire rate_t slowest_rate,
   output logic       link_up,
   output logic       link_error,
   output logic       host_reset_seen,
   output rate_t      line_rate
);
   // ----------------------------------------------------------------
   // handshake state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      d_power   = 3'b000,
      d_init    = 3'b001,
      d_wait    = 3'b011,
      d_wake    = 3'b010,
      d_align   = 3'b110,
      d_sync    = 3'b111,
      d_ready   = 3'b101,
      d_error   = 3'b100
   } dstate_t;
   dstate_t    state, next_state;
   tmr_t       timer, next_timer;
   logic [2:0] run, next_run;
   logic [1:0] na, next_na;
   rate_t      rate, next_rate;
   prim_t      next_prim;
   logic       next_link_up, next_link_error, next_host_reset_seen;
   logic       send, send_wake, busy, rx_reset_end, rx_wake_end;
   logic       host_align, host_other;

   // ----------------------------------------------------------------
   // burst engine
   // ----------------------------------------------------------------
   // the device never holds a train open, so hold is tied off
   oob_burst_port u_oob (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .send         (send),
      .send_wake    (send_wake),
      .hold         (1'b0),
      .busy         (busy),
      .tx_burst     (link.d2h_burst),
      .rx_burst     (link.h2d_burst),
      .rx_reset_end (rx_reset_end),
      .rx_wake_end  (rx_wake_end)
   );

   // ----------------------------------------------------------------
   // receive classification
   // ----------------------------------------------------------------
   // an align only counts toward lock when it comes back at our own rate
   assign host_align = (link.h2d_prim == prim_align) && (link.h2d_rate == rate);
   // idle and d10.2 filler are not primitives, so they do not count as non-align
   assign host_other = (link.h2d_prim == prim_sync);

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_state           = state;
      next_timer           = timer;
      next_run             = run;
      next_na              = na;
      next_rate            = rate;
      next_host_reset_seen = rx_reset_end;
      send                 = 1'b0;
      send_wake            = 1'b0;
      case (state)
         // coming out of reset counts as a late start
         d_power: begin
            next_state = d_init;
            send       = 1'b1;
         end
         // init train goes out; the engine shapes it like a host reset
         d_init: if (!busy) begin
            next_state = d_wait;
         end
         // the host is expected to calibrate and send its wake
         d_wait: if (rx_wake_end) begin
            next_state = d_wake;
            send       = 1'b1;
            send_wake  = 1'b1;
         end
         // optional transmitter calibration is skipped
         d_wake: if (!busy) begin
            next_state = d_align;
            next_rate  = fastest_rate;
            next_timer = '0;
            next_run   = '0;
         end
         d_align: begin
            next_timer = timer + TMR_ONE;
            next_run   = host_align ? run + RUN_ONE : '0;
            if (host_align && run == LOCK_ALIGNS - RUN_ONE) begin
               next_state = d_sync;
               next_na    = '0;
            end else if (timer == ALIGN_TIMEOUT - TMR_ONE) begin
               if (rate == slowest_rate) begin
                  next_state = d_error;
               end else begin
                  next_rate  = rate - RATE_STEP;
                  next_timer = '0;
                  next_run   = '0;
               end
            end
         end
         // sync goes out until three host syncs arrive in a row, and keeps going out in ready
         d_sync: begin
            next_na = host_other ? na + NA_ONE : '0;
            if (host_other && na == NONALIGN_RUN - NA_ONE) begin
               next_state = d_ready;
            end
         end
         default: begin
            next_state = state;                 // ready and error wait for a new start
         end
      endcase
      // a finished host reset or a local request restarts from any state
      if (rx_reset_end || start_init) begin
         next_state = d_init;
         send       = 1'b1;
         send_wake  = 1'b0;
      end
   end

   // primitive choice follows the state being entered, so it is registered cleanly
   always_comb begin
      case (next_state)
         d_align: next_prim = prim_align;
         d_sync:  next_prim = prim_sync;
         d_ready: next_prim = prim_sync;
         default: next_prim = prim_idle;
      endcase
      next_link_up    = (next_state == d_ready);
      next_link_error = (next_state == d_error);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state           <= d_power;
         timer           <= '0;
         run             <= '0;
         na              <= '0;
         rate            <= RATE_GEN1;
         link.d2h_prim   <= prim_idle;
         link.d2h_rate   <= RATE_GEN1;
         link_up         <= 1'b0;
         link_error      <= 1'b0;
         host_reset_seen <= 1'b0;
      end else begin
         state           <= next_state;
         timer           <= next_timer;
         run             <= next_run;
         na              <= next_na;
         rate            <= next_rate;
         link.d2h_prim   <= next_prim;
         link.d2h_rate   <= next_rate;
         link_up         <= next_link_up;
         link_error      <= next_link_error;
         host_reset_seen <= next_host_reset_seen;
      end
   end

   // the rate output mirrors the line rate register
   assign line_rate = rate;
endmodule // oob_device_end

/* File: oob_host_end.sv */
// host end of the oob handshake: reset, wake, lock and retry
// assumes the device end sits on the far side of oob_link_if
module oob_host_end
   import oob_link_pkg::*;
#(
   parameter tmr_t WAIT_TIMEOUT = HOST_WAIT_CYC
)
(
   input  wire logic sys_clk,
   input  wire logic resetn,
   oob_link_if.host  link,
   input  wire logic hold_reset,
   input  wire logic stop,
   input  wire rate_t fastest_rate,
   output logic      link_up,
   output logic      retry,
   output rate_t     line_rate
);
   // ----------------------------------------------------------------
   // handshake state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      h_reset = 3'b000, h_wait_init = 3'b001, h_wake = 3'b011, h_wait_wake = 3'b010,
      h_d10 = 3'b110, h_align = 3'b111, h_ready = 3'b101, h_stop = 3'b100
   } hstate_t;
   hstate_t    state, next_state;
   tmr_t       timer, next_timer;
   logic [2:0] run, next_run;
   logic [1:0] na, next_na;
   logic       sent, next_sent;
   logic       send, send_wake, busy, rx_reset_end, rx_wake_end;
   prim_t      next_prim;
   rate_t      next_rate;
   logic       next_link_up, next_retry;
   logic       seen_align;

   oob_burst_port u_oob (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .send         (send),
      .send_wake    (send_wake),
      .hold         (hold_reset),
      .busy         (busy),
      .tx_burst     (link.h2d_burst),
      .rx_burst     (link.d2h_burst),
      .rx_reset_end (rx_reset_end),
      .rx_wake_end  (rx_wake_end)
   );

   // device aligns above our fastest rate cannot be received at all
   assign seen_align = (link.d2h_prim == prim_align) && (link.d2h_rate <= fastest_rate);

   always_comb begin
      next_state   = state;
      next_timer   = timer + TMR_ONE;
      next_run     = run;
      next_na      = na;
      next_sent    = sent;
      next_rate    = link.h2d_rate;
      next_retry   = 1'b0;
      send         = 1'b0;
      send_wake    = 1'b0;
      case (state)
         h_reset: if (!sent) begin              // device answers are ignored until the train is out and hold_reset drops
            send      = 1'b1;
            next_sent = 1'b1;
         end else if (!busy && !hold_reset) begin
            next_state = h_wait_init;
         end
         h_wait_init: if (rx_reset_end) begin
            next_state = h_wake;
            send       = 1'b1;
            send_wake  = 1'b1;
         end
         h_wake: if (!busy) next_state = h_wait_wake;
         h_wait_wake: if (rx_wake_end) begin
            next_state = h_d10;
            next_timer = '0;
            next_run   = '0;
            next_rate  = RATE_GEN1;
         end
         h_d10: begin
            next_run = seen_align ? run + RUN_ONE : '0;
            if (seen_align && run == LOCK_ALIGNS - RUN_ONE) begin
               next_state = h_align;
               next_rate  = link.d2h_rate;
               next_na    = '0;
            end else if (timer == WAIT_TIMEOUT - TMR_ONE) begin
               next_state = stop ? h_stop : h_reset;
               next_sent  = 1'b0;
               next_retry = !stop;
            end
         end
         h_align: begin
            next_na = (link.d2h_prim == prim_sync) ? na + NA_ONE : '0;
            if (link.d2h_prim == prim_sync && na == NONALIGN_RUN - NA_ONE) begin
               next_state = h_ready;
            end
         end
         h_ready: if (rx_reset_end) begin       // init request during operation
            next_state = h_wake;
            send       = 1'b1;
            send_wake  = 1'b1;
         end
         default: next_timer = timer;
      endcase
      // an init request is answered from any live state, so a device restart never strands us
      if (rx_reset_end && state != h_reset && state != h_stop) begin
         next_state = h_wake;
         send       = 1'b1;
         send_wake  = 1'b1;
      end
      // a system reset level pulls the host back into its reset train
      if (hold_reset && state != h_reset && state != h_stop) begin
         next_state = h_reset;
         next_sent  = 1'b0;
         send       = 1'b0;
         send_wake  = 1'b0;
      end
      case (next_state)
         h_d10:   next_prim = prim_d10_2;
         h_align: next_prim = prim_align;
         h_ready: next_prim = prim_sync;
         default: next_prim = prim_idle;
      endcase
      next_link_up = (next_state == h_ready);
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state         <= h_reset;
         timer         <= '0;
         run           <= '0;
         na            <= '0;
         sent          <= 1'b0;
         link.h2d_prim <= prim_idle;
         link.h2d_rate <= RATE_GEN1;
         link_up       <= 1'b0;
         retry         <= 1'b0;
      end else begin
         state         <= next_state;
         timer         <= next_timer;
         run           <= next_run;
         na            <= next_na;
         sent          <= next_sent;
         link.h2d_prim <= next_prim;
         link.h2d_rate <= next_rate;
         link_up       <= next_link_up;
         retry         <= next_retry;
      end
   end

   assign line_rate = link.h2d_rate;
endmodule // oob_host_end

/* File: oob_link_if.sv */
// the serial pair seen as burst levels plus one primitive and rate per cycle
// assumes both ends share sys_clk; the bench joins the two ends here
interface oob_link_if;
   import oob_link_pkg::*;
   logic  h2d_burst;
   logic  d2h_burst;
   prim_t h2d_prim;
   prim_t d2h_prim;
   rate_t h2d_rate;
   rate_t d2h_rate;
   modport dev  (input h2d_burst, h2d_prim, h2d_rate, output d2h_burst, d2h_prim, d2h_rate);
   modport host (input d2h_burst, d2h_prim, d2h_rate, output h2d_burst, h2d_prim, h2d_rate);
endinterface

/* File: oob_link_monitor.sv */
// checker watching the oob wires between the two ends
// assumes one clock; the bench instantiates it beside the interface
module oob_link_monitor
   import oob_link_pkg::*;
(
   input wire logic  sys_clk,
   input wire logic  resetn,
   input wire logic  h2d_burst,
   input wire logic  d2h_burst,
   input wire prim_t h2d_prim,
   input wire prim_t d2h_prim,
   input wire rate_t h2d_rate,
   input wire rate_t d2h_rate
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------------------------------
   // idle run before a device burst, saturating so a long quiet reads as a new train
   // ----------------------------------------------------------------
   logic [5:0] gap;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) gap <= 6'h3f;
      else if (d2h_burst) gap <= 6'h00;
      else if (gap != 6'h3f) gap <= gap + 6'h01;
   end
   // eleven cycles high, then idle
   sequence s_burst(b);
      b [*8] ##1 b [*3] ##1 !b;
   endsequence
   a_dev_burst_len: assert property ($rose(d2h_burst) |-> s_burst(d2h_burst))
      else $error("device burst length wrong");
   a_host_burst_len: assert property ($rose(h2d_burst) |-> s_burst(h2d_burst))
      else $error("host burst length wrong");
   a_dev_gap_len: assert property ($rose(d2h_burst) |->
      (gap == 6'h0b || gap == 6'h20 || gap >= 6'h35))
      else $error("device burst gap wrong");
   a_burst_quiet_line: assert property (d2h_burst |-> d2h_prim == prim_idle)
      else $error("device prims during burst");
   a_d10_slow_rate: assert property (h2d_prim == prim_d10_2 |-> h2d_rate == RATE_GEN1)
      else $error("host d10.2 not at slowest rate");
   a_host_echo_rate: assert property ($rose(h2d_prim == prim_align) |->
      h2d_rate == $past(d2h_rate))
      else $error("host align at other rate");
   a_sync_after_lock: assert property ($rose(d2h_prim == prim_sync) |->
      $past(h2d_prim == prim_align) && $past(h2d_rate == d2h_rate))
      else $error("device sync without host align");
   a_rate_step_down: assert property (
      d2h_prim == prim_align && $past(d2h_prim == prim_align) && $changed(d2h_rate)
      |-> d2h_rate == $past(d2h_rate) - RATE_STEP ##1 $stable(d2h_rate) [*8])
      else $error("device rate step wrong");
   a_host_sync_order: assert property ($rose(h2d_prim == prim_sync) |->
      $past(d2h_prim == prim_sync))
      else $error("host sync before device sync");
   // every host accepts the slowest rate, so aligns there must be echoed within a few cycles
   a_host_lock_time: assert property (
      $rose(d2h_prim == prim_align && d2h_rate == RATE_GEN1) |-> ##[1:8] h2d_prim == prim_align)
      else $error("host lock too slow");
endmodule // oob_link_monitor

/* File: oob_link_pkg.sv */
// constants, types and timing counts shared by both ends of the oob link
// assumes a single 100 MHz clock on both ends and one dword per cycle on the prim wires
package oob_link_pkg;
   // ----------------------------------------------------------------
   // line model
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      prim_idle  = 2'h0,
      prim_d10_2 = 2'h1,
      prim_align = 2'h2,
      prim_sync  = 2'h3
   } prim_t;
   typedef logic [1:0] rate_t;              // 0 slowest generation, 2 fastest
   localparam rate_t RATE_GEN1 = 2'h0;
   localparam rate_t RATE_STEP = 2'h1;

   // ----------------------------------------------------------------
   // burst timing, cycles derived from printed times
   // ----------------------------------------------------------------
   localparam int CLK_PS          = 10000;
   localparam int BURST_PS        = 106700;
   localparam int GAP_PS          = 320000;
   localparam int WAKE_GAP_PS     = 106700;
   localparam int GAP_MIN_PS      = 175000;
   localparam int GAP_MAX_PS      = 525000;
   localparam int WAKE_GAP_MIN_PS = 40000;
   localparam int HOLD_IDLE_PS    = 525000;
   localparam int CNT_W           = 6;
   typedef logic [CNT_W-1:0] ocnt_t;
   localparam ocnt_t BURST_CYC    = CNT_W'((BURST_PS + CLK_PS - 1) / CLK_PS);
   localparam ocnt_t GAP_CYC      = CNT_W'((GAP_PS + CLK_PS - 1) / CLK_PS);
   localparam ocnt_t WAKE_GAP_CYC = CNT_W'((WAKE_GAP_PS + CLK_PS - 1) / CLK_PS);
   localparam ocnt_t GAP_MIN_CYC  = CNT_W'((GAP_MIN_PS + CLK_PS - 1) / CLK_PS);
   localparam ocnt_t GAP_MAX_CYC  = CNT_W'(GAP_MAX_PS / CLK_PS);
   localparam ocnt_t WGAP_MIN_CYC = CNT_W'((WAKE_GAP_MIN_PS + CLK_PS - 1) / CLK_PS);
   localparam ocnt_t HOLD_CYC     = CNT_W'((HOLD_IDLE_PS + CLK_PS - 1) / CLK_PS);
   localparam ocnt_t CNT_ONE      = 6'h01;
   localparam ocnt_t CNT_SAT      = 6'h3f;

   // ----------------------------------------------------------------
   // burst counts and handshake runs
   // ----------------------------------------------------------------
   localparam logic [2:0] SEQ_BURSTS  = 3'h6;   // reset, init and wake all send six
   localparam logic [2:0] DET_BURSTS  = 3'h4;
   localparam logic [2:0] LOCK_ALIGNS = 3'h4;   // aligns seen before a receiver counts as locked
   localparam logic [2:0] RUN_ONE     = 3'h1;
   localparam logic [1:0] NONALIGN_RUN = 2'h3;
   localparam logic [1:0] NA_ONE      = 2'h1;

   // ----------------------------------------------------------------
   // long handshake timeouts (2048 and 32768 gen1 dword times)
   // ----------------------------------------------------------------
   localparam int ALIGN_WAIT_NS = 54600;
   localparam int HOST_WAIT_NS  = 873800;
   localparam int TMR_W         = 17;
   typedef logic [TMR_W-1:0] tmr_t;
   localparam tmr_t ALIGN_WAIT_CYC = TMR_W'(ALIGN_WAIT_NS * 1000 / CLK_PS);
   localparam tmr_t HOST_WAIT_CYC  = TMR_W'(HOST_WAIT_NS * 1000 / CLK_PS);
   localparam tmr_t TMR_ONE        = 17'h00001;
endpackage

/* File: tb_serial_ata_oob_link_init.sv */
// self-checking bench joining host and device ends over one interface
// assumes shortened timeouts: align window 200, host wait 2000 cycles
module tb_serial_ata_oob_link_init
   import oob_link_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic  sys_clk, resetn, start_init, hold_reset, stop;
   logic  d_up, d_err, d_seen, h_up, h_retry;
   rate_t host_fast, dev_fast, dev_slow, d_rate, h_rate;
   int    n_errors, samples_checked, n_retry, n_seen, k, i;
   oob_link_if oob_link_if_i ();
   oob_device_end #(.ALIGN_TIMEOUT(tmr_t'(200))) oob_device_end_i (.sys_clk(sys_clk),
      .resetn(resetn), .link(oob_link_if_i), .start_init(start_init), .fastest_rate(dev_fast),
      .slowest_rate(dev_slow), .link_up(d_up), .link_error(d_err), .host_reset_seen(d_seen),
      .line_rate(d_rate));
   oob_host_end #(.WAIT_TIMEOUT(tmr_t'(2000))) oob_host_end_i (.sys_clk(sys_clk),
      .resetn(resetn), .link(oob_link_if_i), .hold_reset(hold_reset), .stop(stop),
      .fastest_rate(host_fast), .link_up(h_up), .retry(h_retry), .line_rate(h_rate));
   oob_link_monitor oob_link_monitor_i (.sys_clk(sys_clk), .resetn(resetn),
      .h2d_burst(oob_link_if_i.h2d_burst), .d2h_burst(oob_link_if_i.d2h_burst),
      .h2d_prim(oob_link_if_i.h2d_prim), .d2h_prim(oob_link_if_i.d2h_prim),
      .h2d_rate(oob_link_if_i.h2d_rate), .d2h_rate(oob_link_if_i.d2h_rate));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // the device settles on the faster rate both ends can carry
   function automatic rate_t exp_rate(rate_t hf, rate_t df);
      return (hf < df) ? hf : df;
   endfunction
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic check(string name, logic [3:0] exp, logic [3:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic test_done();
      if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      if (h_retry === 1'b1) n_retry++;
      if (d_seen === 1'b1) n_seen++;
   end
   // full handshakes run near 1000 cycles, so this only trips on a hang
   initial begin
      repeat (95000) @(posedge sys_clk);
      n_errors++;
      test_done();
   end
   // ----------------------------------------------------------------
   // main sequence: power-on, random rate pairs, forced error, host reset, stop
   // ----------------------------------------------------------------
   initial begin
      {resetn, start_init, hold_reset, stop} = 4'h0;
      {host_fast, dev_fast, dev_slow} = 6'h20;
      k = $urandom(64);
      repeat (20) tick();
      resetn = 1'b1;
      for (i = 0; i < 8; i++) begin
         if (i > 0) begin
            host_fast = rate_t'($urandom % 3);
            dev_fast = rate_t'($urandom % 3);
            dev_slow = rate_t'($urandom % (dev_fast + 1));
            if (i == 1 || i == 7) {host_fast, dev_fast, dev_slow} = 6'h09;
            if (i == 7) stop = 1'b1;
            if (i == 3) hold_reset = 1'b1;
            else start_init = 1'b1;
            tick();
            start_init = 1'b0;
            if (i == 3) repeat (400) tick();
            if (i == 3) check("host up in reset", 4'h0, 4'(h_up));
            hold_reset = 1'b0;
            repeat (3) tick();
         end
         if (host_fast < dev_slow) begin
            for (k = 0; k < 3000 && d_err !== 1'b1; k++) tick();
            check("device error", 4'h1, 4'(d_err));
            check("error rate", 4'(dev_slow), 4'(d_rate));
            k = n_retry;
            repeat (2600) tick();
            // with stop set the host parks instead of retrying
            check("host retried", {3'h0, i != 7}, 4'(n_retry > k));
            // park the device in error again so the next request never cuts a train
            for (k = 0; k < 3000 && d_err !== 1'b1; k++) tick();
            check("device error again", 4'h1, 4'(d_err));
         end else begin
            for (k = 0; k < 8000 && !(d_up === 1'b1 && h_up === 1'b1); k++) tick();
            check("device up", 4'h1, 4'(d_up));
            check("host up", 4'h1, 4'(h_up));
            check("device rate", 4'(exp_rate(host_fast, dev_fast)), 4'(d_rate));
            check("host rate", 4'(exp_rate(host_fast, dev_fast)), 4'(h_rate));
            check("reset end seen", 4'h1, 4'(n_seen > 0));
         end
      end
      test_done();
   end
endmodule // tb_serial_ata_oob_link_init
